/* File: pwm_dt_pkg.sv */
/*
 Package for the six-output PWM generator with deadtime.
 Holds Wishbone register offsets, field positions, reset values and the
 state struct. Assumes a 32-bit classic Wishbone master with byte addresses.
*/
package pwm_dt_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_CORR = 8'h08;
  localparam logic [7:0] OFS_MOD = 8'h0C;
  localparam logic [7:0] OFS_DT_RISE = 8'h10;
  localparam logic [7:0] OFS_DT_FALL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_DUTY0 = 8'h20;
  localparam logic [7:0] OFS_DUTY_LAST = 8'h34;

  // ==========================================================================
  // Field positions
  // config: [0] align_select, [3:1] pair_independent, [9:4] compare_invert
  localparam int CFG_ALIGN = 0;
  localparam int CFG_INDEP = 1;
  localparam int CFG_CINV = 4;
  // ctrl: [0] enable, [1] load_okay, [3:2] prescale
  localparam int CTL_EN = 0;
  localparam int CTL_LOAD_OKAY = 1;
  localparam int CTL_PRSC = 2;
  // corr: [2:0] correction_select, [6:4] correction_source
  localparam int COR_SEL = 0;
  localparam int COR_SRC = 4;

  localparam int NUM_CH = 6;
  localparam int NUM_PAIR = 3;
  localparam int CNT_W = 15;
  localparam int DUTY_W = 16;
  localparam int DT_W = 12;

  // Reset values
  localparam logic [CNT_W-1:0] MOD_RST = 15'h0001;
  localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;
  localparam logic [2:0] PRE_ONE = 3'h1;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // Two-stage path in front of the deadtime logic
  localparam int DT_PIPE = 2;

  typedef struct packed {
    logic [DUTY_W-1:0] val;
    logic [CNT_W-1:0] cnt;
  } duty_slot_t;

  typedef struct packed {
    // Software-visible registers
    logic align_select;
    logic [NUM_PAIR-1:0] pair_independent;
    logic [NUM_CH-1:0] compare_invert;
    logic enable;
    logic load_okay;
    logic [1:0] prescale;
    logic [NUM_PAIR-1:0] correction_select;
    logic [NUM_PAIR-1:0] correction_source;
    logic [CNT_W-1:0] modulus;
    logic [DT_W-1:0] rise_dt;
    logic [DT_W-1:0] fall_dt;
    logic [NUM_CH-1:0][DUTY_W-1:0] duty;
    // Working buffers
    logic [CNT_W-1:0] mod_buf;
    logic [NUM_CH-1:0][DUTY_W-1:0] duty_buf;
    logic [1:0] pre_buf;
    logic load_pend;
    logic [NUM_PAIR-1:0] sel_buf;
    logic [NUM_PAIR-1:0] src_buf;
    // Generator
    logic [2:0] pre_cnt;
    logic tick;
    logic [CNT_W-1:0] cnt;
    logic down;
    logic [NUM_CH-1:0] cmp;
    logic [DT_PIPE-1:0][NUM_CH-1:0] pipe;
    logic [NUM_PAIR-1:0][DT_W-1:0] dt_cnt;
    logic [NUM_CH-1:0] pwm;
    // Bus
    logic ack;
    logic [31:0] rdata;
  } pwm_state_t;

endpackage

/* File: pwm_generator_with_deadtime.sv */
/*
 Six-output PWM generator: shared 15-bit up/down counter, edge or center
 alignment, compare invert, complementary pairs with rise/fall deadtime and
 odd/even duty selection. Registers are a classic Wishbone slave.
 Assumes a single 100 MHz clock and a master that holds cyc/stb until ack.
*/
`timescale 1ns/10ps
module pwm_generator_with_deadtime #(
  parameter int NUM_CH = pwm_dt_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Gate drive outputs, even index top, odd index bottom
  output logic [NUM_CH-1:0] pwm_out
);

  pwm_dt_pkg::pwm_state_t s_reg;
  pwm_dt_pkg::pwm_state_t s_next;

  // ==========================================================================
  // Combinational helpers
  logic bus_req;
  logic [2:0] duty_idx;
  logic cycle_end;
  logic [pwm_dt_pkg::CNT_W-1:0] top_val;

  assign bus_req = wb_cyc_in & wb_stb_in & ~s_reg.ack;
  assign duty_idx = 3'((wb_adr_in - pwm_dt_pkg::OFS_DUTY0) >> 2);
  // End of period: counter at modulus while counting up (edge) or back at one while counting down (center)
  assign cycle_end = s_reg.tick & (s_reg.align_select ? s_reg.cnt >= s_reg.mod_buf
                     : (s_reg.down & s_reg.cnt <= pwm_dt_pkg::CNT_ONE));
  assign top_val = s_reg.mod_buf;

  always_comb begin
    logic [pwm_dt_pkg::DUTY_W-1:0] used;
    logic [pwm_dt_pkg::CNT_W-1:0] uv;
    logic pre_top;
    logic rise;
    logic fall;
    logic [2:0] div;
    used = '0;
    uv = '0;
    pre_top = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    div = pwm_dt_pkg::PRE_ONE << s_reg.pre_buf;
    s_next = s_reg;

    // ========================================================================
    // Wishbone slave: one-cycle ack, writes take effect with ack
    s_next.ack = bus_req;
    s_next.rdata = pwm_dt_pkg::RD_ZERO;
    if (bus_req) begin
      unique case (wb_adr_in)
        pwm_dt_pkg::OFS_CONFIG: begin
          s_next.rdata[pwm_dt_pkg::CFG_ALIGN] = s_reg.align_select;
          s_next.rdata[pwm_dt_pkg::CFG_INDEP +: 3] = s_reg.pair_independent;
          s_next.rdata[pwm_dt_pkg::CFG_CINV +: 6] = s_reg.compare_invert;
          if (wb_we_in && wb_sel_in[0]) begin
            s_next.align_select = wb_dat_in[pwm_dt_pkg::CFG_ALIGN];
            s_next.pair_independent = wb_dat_in[pwm_dt_pkg::CFG_INDEP +: 3];
          end
          if (wb_we_in && wb_sel_in[0] && wb_sel_in[1]) begin
            s_next.compare_invert = wb_dat_in[pwm_dt_pkg::CFG_CINV +: 6];
          end
        end
        pwm_dt_pkg::OFS_CTRL: begin
          s_next.rdata[pwm_dt_pkg::CTL_EN] = s_reg.enable;
          s_next.rdata[pwm_dt_pkg::CTL_LOAD_OKAY] = s_reg.load_okay;
          s_next.rdata[pwm_dt_pkg::CTL_PRSC +: 2] = s_reg.prescale;
          if (wb_we_in && wb_sel_in[0]) begin
            s_next.enable = wb_dat_in[pwm_dt_pkg::CTL_EN];
            s_next.prescale = wb_dat_in[pwm_dt_pkg::CTL_PRSC +: 2];
            if (wb_dat_in[pwm_dt_pkg::CTL_LOAD_OKAY]) begin
              s_next.load_okay = 1'b1;
            end
          end
        end
        pwm_dt_pkg::OFS_CORR: begin
          s_next.rdata[pwm_dt_pkg::COR_SEL +: 3] = s_reg.correction_select;
          s_next.rdata[pwm_dt_pkg::COR_SRC +: 3] = s_reg.correction_source;
          if (wb_we_in && wb_sel_in[0]) begin
            s_next.correction_select = wb_dat_in[pwm_dt_pkg::COR_SEL +: 3];
            s_next.correction_source = wb_dat_in[pwm_dt_pkg::COR_SRC +: 3];
          end
        end
        pwm_dt_pkg::OFS_MOD: begin
          s_next.rdata[pwm_dt_pkg::CNT_W-1:0] = s_reg.modulus;
          if (wb_we_in && wb_sel_in[0] && wb_sel_in[1]) begin
            s_next.modulus = wb_dat_in[pwm_dt_pkg::CNT_W-1:0];
          end
        end
        pwm_dt_pkg::OFS_DT_RISE: begin
          s_next.rdata[pwm_dt_pkg::DT_W-1:0] = s_reg.rise_dt;
          if (wb_we_in && wb_sel_in[0] && wb_sel_in[1]) begin
            s_next.rise_dt = wb_dat_in[pwm_dt_pkg::DT_W-1:0];
          end
        end
        pwm_dt_pkg::OFS_DT_FALL: begin
          s_next.rdata[pwm_dt_pkg::DT_W-1:0] = s_reg.fall_dt;
          if (wb_we_in && wb_sel_in[0] && wb_sel_in[1]) begin
            s_next.fall_dt = wb_dat_in[pwm_dt_pkg::DT_W-1:0];
          end
        end
        pwm_dt_pkg::OFS_STATUS: begin
          // Live counter and direction for software
          s_next.rdata[pwm_dt_pkg::CNT_W-1:0] = s_reg.cnt;
          s_next.rdata[pwm_dt_pkg::CNT_W] = s_reg.down;
        end
        default: begin
          if (wb_adr_in >= pwm_dt_pkg::OFS_DUTY0 && wb_adr_in <= pwm_dt_pkg::OFS_DUTY_LAST
              && wb_adr_in[1:0] == 2'h0) begin
            s_next.rdata[pwm_dt_pkg::DUTY_W-1:0] = s_reg.duty[duty_idx];
            if (wb_we_in && wb_sel_in[0] && wb_sel_in[1]) begin
              s_next.duty[duty_idx] = wb_dat_in[pwm_dt_pkg::DUTY_W-1:0];
            end
          end
        end
      endcase
    end

    // ========================================================================
    // Load: mark pending now, copy into buffers at the next reload
    if (s_reg.load_okay) begin
      s_next.load_okay = 1'b0;
      s_next.load_pend = 1'b1;
    end

    // ========================================================================
    // Prescaler: tick every 1, 2 or 4 clocks; prescale 3 wraps div to 0, so it ticks every clock
    s_next.tick = 1'b0;
    if (s_reg.enable) begin
      if (s_reg.pre_cnt + 3'h1 >= div) begin
        s_next.pre_cnt = '0;
        s_next.tick = 1'b1;
      end else begin
        s_next.pre_cnt = s_reg.pre_cnt + 3'h1;
      end
    end

    // ========================================================================
    // Shared counter, 1..modulus (edge) or 0..modulus (center)
    if (s_reg.tick) begin
      if (cycle_end) begin
        s_next.cnt = pwm_dt_pkg::CNT_ONE;
        s_next.down = 1'b0;
        if (s_reg.align_select) begin
          s_next.cnt = pwm_dt_pkg::CNT_ONE;
        end else begin
          s_next.cnt = '0;
        end
        s_next.sel_buf = s_reg.correction_select;
        s_next.src_buf = s_reg.correction_source;
        if (s_reg.load_pend) begin
          s_next.load_pend = 1'b0;
          s_next.mod_buf = s_reg.modulus;
          s_next.duty_buf = s_reg.duty;
          s_next.pre_buf = s_reg.prescale;
          s_next.pre_cnt = '0;
        end
      end else if (!s_reg.align_select && !s_reg.down && s_reg.cnt >= top_val) begin
        s_next.down = 1'b1;
        s_next.cnt = s_reg.cnt - pwm_dt_pkg::CNT_ONE;
      end else if (s_reg.down) begin
        s_next.cnt = s_reg.cnt - pwm_dt_pkg::CNT_ONE;
      end else begin
        s_next.cnt = s_reg.cnt + pwm_dt_pkg::CNT_ONE;
      end
    end

    // ========================================================================
    // Compare: center sets on the way down, clears on match going up
    for (int i = 0; i < NUM_CH; i++) begin
      used = s_reg.duty_buf[i][pwm_dt_pkg::DUTY_W-1] ? '0 : s_reg.duty_buf[i];
      uv = used[pwm_dt_pkg::CNT_W-1:0];
      if (uv == '0) begin
        s_next.cmp[i] = s_reg.compare_invert[i];
      end else if (uv >= s_reg.mod_buf) begin
        s_next.cmp[i] = ~s_reg.compare_invert[i];
      end else if (s_reg.align_select) begin
        // Edge: active from cycle start until count reaches duty
        s_next.cmp[i] = (s_reg.cnt <= uv) ^ s_reg.compare_invert[i];
      end else if (s_reg.down && uv >= s_reg.cnt) begin
        // Set one count early so 0 and top, each seen once, still give 2*duty
        s_next.cmp[i] = ~s_reg.compare_invert[i];
      end else if (!s_reg.down && s_reg.cnt >= uv) begin
        s_next.cmp[i] = s_reg.compare_invert[i];
      end
    end

    // ========================================================================
    // Pair shaping and two-stage delay ahead of deadtime
    s_next.pipe[1] = s_reg.pipe[0];
    for (int p = 0; p < pwm_dt_pkg::NUM_PAIR; p++) begin
      if (s_reg.pair_independent[p]) begin
        s_next.pipe[0][2*p] = s_reg.cmp[2*p];
        s_next.pipe[0][2*p+1] = s_reg.cmp[2*p+1];
      end else begin
        // Direction source: up uses even, down uses odd
        pre_top = (s_reg.src_buf[p] ? s_reg.down : s_reg.sel_buf[p]) ?
                  s_reg.cmp[2*p+1] : s_reg.cmp[2*p];
        s_next.pipe[0][2*p] = pre_top;
        s_next.pipe[0][2*p+1] = ~pre_top;
      end
    end

    // ========================================================================
    // Deadtime: both outputs held off while the counter runs
    for (int p = 0; p < pwm_dt_pkg::NUM_PAIR; p++) begin
      if (s_reg.pair_independent[p]) begin
        s_next.pwm[2*p] = s_reg.pipe[1][2*p];
        s_next.pwm[2*p+1] = s_reg.pipe[1][2*p+1];
        s_next.dt_cnt[p] = '0;
      end else begin
        rise = s_reg.pipe[0][2*p] & ~s_reg.pipe[1][2*p];
        fall = ~s_reg.pipe[0][2*p] & s_reg.pipe[1][2*p];
        if (rise && s_reg.rise_dt != '0) begin
          // Edge cycle is the first deadtime cycle, so load one less
          s_next.dt_cnt[p] = s_reg.rise_dt - pwm_dt_pkg::DT_W'(1);
          s_next.pwm[2*p] = 1'b0;
          s_next.pwm[2*p+1] = 1'b0;
        end else if (fall && s_reg.fall_dt != '0) begin
          s_next.dt_cnt[p] = s_reg.fall_dt - pwm_dt_pkg::DT_W'(1);
          s_next.pwm[2*p] = 1'b0;
          s_next.pwm[2*p+1] = 1'b0;
        end else if (s_reg.dt_cnt[p] != '0) begin
          if (s_reg.tick) begin
            s_next.dt_cnt[p] = s_reg.dt_cnt[p] - 1'b1;
          end
          s_next.pwm[2*p] = 1'b0;
          s_next.pwm[2*p+1] = 1'b0;
        end else begin
          // Never both on, even with a bad modulus
          s_next.pwm[2*p] = s_reg.pipe[1][2*p];
          s_next.pwm[2*p+1] = ~s_reg.pipe[1][2*p];
        end
      end
    end
    if (!s_reg.enable) begin
      s_next.pwm = '0;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_reg <= '0;
      s_reg.modulus <= pwm_dt_pkg::MOD_RST;
      s_reg.mod_buf <= pwm_dt_pkg::MOD_RST;
      s_reg.pair_independent <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_out = s_reg.rdata;
  assign wb_ack_out = s_reg.ack;
  assign pwm_out = s_reg.pwm;

endmodule

/* File: pwm_gate_model.sv */
/*
 Gate-drive model for the three inverter legs.
 Counts on-time of each gate and top/bottom overlap; clr_in restarts counts.
*/
`timescale 1ns/10ps
module pwm_gate_model (
  // Clock and control
  input wire logic clk_in,
  input wire logic clr_in,
  // Gates, even top, odd bottom
  input wire logic [5:0] gate_in,
  output logic [5:0][31:0] on_cnt_out,
  output logic [31:0] overlap_out
);
  always_ff @(posedge clk_in) begin
    if (clr_in) begin
      on_cnt_out <= '0;
      overlap_out <= 32'h0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        on_cnt_out[i] <= on_cnt_out[i] + 32'(gate_in[i]);
      end
      // Both switches of one leg on shorts the supply
      for (int p = 0; p < 3; p++) begin
        if (gate_in[2*p] && gate_in[2*p+1]) begin
          overlap_out <= overlap_out + 32'h1;
        end
      end
    end
  end
endmodule

/* File: pwm_generator_with_deadtime_monitor.sv */
/*
 Checker for the PWM core: bus handshake, pair overlap and deadtime gaps.
 Sees only top ports; assumes deadtime of at least two set before pairing.
*/
`timescale 1ns/10ps
module pwm_generator_with_deadtime_monitor #(
  parameter int NUM_CH = 6
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic [NUM_CH-1:0] pwm_out
);
  // ==========================================================================
  // Pair mode seen on the bus; age lets the output pipeline settle
  logic [2:0] indep_reg;
  logic [3:0] age_reg;
  logic req;
  logic ok0;
  logic ok1;
  assign req = wb_cyc_in && wb_stb_in;
  assign ok0 = !indep_reg[0] && age_reg == 4'hF;
  assign ok1 = !indep_reg[1] && age_reg == 4'hF;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      indep_reg <= 3'h7;
      age_reg <= 4'h0;
    end else if (wb_ack_out && wb_we_in && wb_adr_in == pwm_dt_pkg::OFS_CONFIG) begin
      indep_reg <= wb_dat_in[3:1];
      age_reg <= 4'h0;
    end else if (age_reg != 4'hF) begin
      age_reg <= age_reg + 4'h1;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  a_ack_answer: assert property (req && !wb_ack_out |=> wb_ack_out) else $error("no ack");
  a_ack_cause: assert property (wb_ack_out |-> $past(req)) else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("data idle");
  a_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 8'h1C
    |-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
  a_leg0_exclusive: assert property (ok0 |-> !(pwm_out[0] && pwm_out[1]))
    else $error("leg 0 overlap");
  a_leg1_exclusive: assert property (ok1 |-> !(pwm_out[2] && pwm_out[3]))
    else $error("leg 1 overlap");
  a_gap_before_bottom: assert property (ok0 && $rose(pwm_out[1])
    |-> $past(!pwm_out[0]) && $past(pwm_out[1:0] == 2'h0, 2)) else $error("no gap bottom");
  a_gap_before_top: assert property (ok0 && $rose(pwm_out[0])
    |-> $past(!pwm_out[1]) && $past(pwm_out[1:0] == 2'h0, 2)) else $error("no gap top");
  c_write: cover property (wb_ack_out && wb_we_in);
  c_bottom_on: cover property (ok0 && $rose(pwm_out[1]));
  c_top_on: cover property (ok1 && $rose(pwm_out[2]));
endmodule
bind pwm_generator_with_deadtime pwm_generator_with_deadtime_monitor #(.NUM_CH(NUM_CH))
  pwm_generator_with_deadtime_monitor_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .pwm_out(pwm_out));

/* File: pwm_generator_with_deadtime_tb_top.sv */
/*
 Bench for the PWM core: Wishbone register access and on-time counts.
 Assumes the gate model counts each output; waits cover reload and pipeline.
*/
`timescale 1ns/10ps
module pwm_generator_with_deadtime_tb_top;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [5:0] pwm;
  logic clr = 1'b1;
  logic [5:0][31:0] on_cnt;
  logic [31:0] overlap;
  logic [31:0] rd;
  int mismatches = 0;
  int n_checks = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  pwm_generator_with_deadtime pwm_generator_with_deadtime_i (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .pwm_out(pwm));
  pwm_gate_model pwm_gate_model_i (.clk_in(sys_clk_in), .clr_in(clr), .gate_in(pwm),
    .on_cnt_out(on_cnt), .overlap_out(overlap));
  // ==========================================================================
  // Tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  // Waits, then counts on-time over n cycles and compares per channel
  task automatic check_on(input int w, input int n, input logic [31:0] e0, e1, e2, e3, e4, e5);
    logic [5:0][31:0] e;
    e = {e5, e4, e3, e2, e1, e0};
    repeat (w) @(posedge sys_clk_in);
    clr <= 1'b1;
    @(posedge sys_clk_in);
    clr <= 1'b0;
    repeat (n) @(posedge sys_clk_in);
    #1;
    for (int i = 0; i < 6; i++) begin
      check32(on_cnt[i], e[i]);
    end
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    wb(1'b1, 8'h00, 32'h2F);
    wb(1'b0, 8'h00, 32'h0);
    check32(rd, 32'h2F);
    wb(1'b0, 8'h1C, 32'h0);
    check32(rd, 32'h0);
    wb(1'b1, 8'h0C, 32'h14);
    wb(1'b1, 8'h20, 32'h5);
    wb(1'b1, 8'h24, 32'h5);
    wb(1'b1, 8'h28, 32'h8000);
    wb(1'b1, 8'h2C, 32'h0);
    wb(1'b1, 8'h30, 32'h19);
    wb(1'b1, 8'h34, 32'h7FFF);
    wb(1'b0, 8'h28, 32'h0);
    check32(rd, 32'h8000);
    wb(1'b1, 8'h04, 32'h3);
    check_on(60, 80, 32'h14, 32'h3C, 32'h0, 32'h0, 32'h50, 32'h50);
    $display("edge independent done");
    wb(1'b1, 8'h20, 32'h8);
    check_on(40, 80, 32'h14, 32'h3C, 32'h0, 32'h0, 32'h50, 32'h50);
    wb(1'b1, 8'h04, 32'h7);
    check_on(120, 160, 32'h40, 32'h78, 32'h0, 32'h0, 32'hA0, 32'hA0);
    $display("load and prescale done");
    wb(1'b1, 8'h00, 32'h2E);
    wb(1'b1, 8'h0C, 32'hA);
    wb(1'b1, 8'h20, 32'h3);
    wb(1'b1, 8'h24, 32'h3);
    wb(1'b1, 8'h04, 32'h3);
    check_on(120, 80, 32'h18, 32'h38, 32'h0, 32'h0, 32'h50, 32'h50);
    $display("center done");
    wb(1'b1, 8'h10, 32'h2);
    wb(1'b1, 8'h14, 32'h3);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h0C, 32'h14);
    wb(1'b1, 8'h20, 32'h5);
    wb(1'b1, 8'h24, 32'hA);
    wb(1'b1, 8'h28, 32'hA);
    wb(1'b1, 8'h2C, 32'h5);
    wb(1'b1, 8'h30, 32'h8000);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b1, 8'h04, 32'h3);
    check_on(80, 80, 32'h0C, 32'h30, 32'h20, 32'h1C, 32'h0, 32'h50);
    check32(overlap, 32'h0);
    wb(1'b1, 8'h08, 32'h3);
    check_on(60, 80, 32'h20, 32'h1C, 32'h0C, 32'h30, 32'h0, 32'h50);
    wb(1'b1, 8'h08, 32'h13);
    check_on(60, 80, 32'h0C, 32'h30, 32'h0C, 32'h30, 32'h0, 32'h50);
    check32(overlap, 32'h0);
    $display("complementary done");
    summarize();
  end
endmodule
